// *** inc/sfs_cfg.svh ***
// offsets, field positions, reset values and timing counts of the function setting block
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define SFS_A_CTRL 8'h00
`define SFS_A_ANGLE 8'h04
`define SFS_A_DELAY 8'h08
`define SFS_A_LIFT 8'h0C
`define SFS_A_COUNT 8'h10
`define SFS_A_STAT 8'h14
// ****************************************
// control field positions
// ****************************************
`define SFS_F_CNT 0
`define SFS_F_REV 1
`define SFS_F_DIAL 3
`define SFS_F_COMP 5
`define SFS_F_NL 6
`define SFS_F_PM 7
`define SFS_F_OF 10
// ****************************************
// legal ranges and codes
// ****************************************
`define SFS_DIAL_MAX 2'h2
`define SFS_PM_MAX 3'h6
`define SFS_OF_MAX 4'hA
`define SFS_OF_STOP 4'hA
`define SFS_ANGLE_MAX 9'h167
`define SFS_DELAY_MAX 9'h1F4
`define SFS_LIFT_MIN 9'h001
`define SFS_LIFT_MAX 9'h1F4
// ****************************************
// reset values
// ****************************************
`define SFS_ANGLE_RST 9'h000
`define SFS_DELAY_RST 9'h000
`define SFS_LIFT_RST 9'h064
`define SFS_COUNT_RST 16'h0000
// ****************************************
// timing
// ****************************************
`define SFS_MS_NS 1000000
`define SFS_CLK_NS 50
`endif

// *** inc/sfs_pkg.sv ***
// types shared by the function setting block
package sfs_pkg;
  typedef logic [7:0] sfs_addr_t;
  typedef logic [31:0] sfs_word_t;
  typedef enum logic [1:0] {sfs_rev_normal, sfs_rev_lvl_sync, sfs_rev_lvl, sfs_rev_alt} sfs_rev_e;
  typedef enum logic [1:0] {sfs_dial_none, sfs_dial_analog, sfs_dial_digital} sfs_dial_e;
  typedef enum logic [2:0] {
    sfs_pm_level, sfs_pm_toggle, sfs_pm_max_lvl, sfs_pm_max_tog,
    sfs_pm_wrap_sync, sfs_pm_wrap_lvl, sfs_pm_wrap_alt
  } sfs_pm_e;
  typedef enum logic [1:0] {sfs_brk_idle, sfs_brk_wait, sfs_brk_turn, sfs_brk_hold} sfs_brk_e;
endpackage : sfs_pkg

// *** core/sfs_sync.sv ***
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module sfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
  assign q = q_r;
endmodule : sfs_sync

// *** core/sfs_timer.sv ***
// millisecond delay timer: done pulses after ms milliseconds from start
`timescale 1ns/100ps
module sfs_timer #(
  parameter int unsigned MS_CYC = 20000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request and answer
  input wire logic start,
  input wire logic [8:0] ms,
  output logic done
);
  localparam int PW = $clog2(MS_CYC + 1);
  logic [PW-1:0] pre_r;
  logic [8:0] ms_r;
  logic run_r;
  logic done_r;
  // a new start restarts the count, so a late retrigger never yields an early done
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_r <= '0;
      ms_r <= 9'h000;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        run_r <= 1'b1;
        ms_r <= ms;
        pre_r <= '0;
      end else if (run_r) begin
        if (ms_r == 9'h000) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end else if (pre_r == PW'(MS_CYC - 1)) begin
          pre_r <= '0;
          ms_r <= ms_r - 9'h001;
        end else begin
          pre_r <= pre_r + PW'(1);
        end
      end
    end
  end
  assign done = done_r;
endmodule : sfs_timer

// *** core/sfs_top.sv ***
// function setting logic of a sewing motor control box, with apb register access
//
// Function
// - count one per finished thread trim
// - counting 1 on, 0 off; off blanks
// - counting ignored without sensor or with panel
// - reverse switch modes 0 to 3 decoded
// - dial selection none, analog, digital decoded
// - brake at upper loss or after angle
// - altv output delayed 0 to 500 ms
// - neutral lift at second neutral position
// - neutral lift uses trimming lift time
// - compensation switch: up/down or one stitch
// - mode 0 presser follows pedal level
// - mode 1 pedal press toggles presser
// - modes 2 and 3 force altv maximum
// - modes 4 to 6 drive wrapper control
// - output code 10 shows machine stopped
`timescale 1ns/100ps
`include "sfs_cfg.svh"
module sfs_top #(
  parameter int unsigned MS_CYC = `SFS_MS_NS / `SFS_CLK_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sfs_pkg::sfs_addr_t paddr,
  input wire sfs_pkg::sfs_word_t pwdata,
  output sfs_pkg::sfs_word_t prdata,
  output logic pready,
  output logic pslverr,
  // operator and machine pins
  input wire logic edge_sensor_fitted,
  input wire logic panel_connected,
  input wire logic trim_done,
  input wire logic upper_detect,
  input wire logic angle_tick,
  input wire logic reverse_lift_req,
  input wire logic reverse_switch,
  input wire logic presser_pedal,
  input wire logic altv_switch,
  input wire logic pedal_neutral,
  input wire logic auto_lowered,
  input wire logic comp_switch,
  input wire logic machine_stopped,
  // actuator and panel outputs
  output logic presser_lift,
  output logic wrapper_on,
  output logic reverse_feed,
  output logic altv_out,
  output logic altv_max,
  output logic brake_start,
  output logic dial_analog_en,
  output logic alternate_vertical_dial_digital,
  output logic comp_updown,
  output logic comp_one_stitch,
  output logic count_blank,
  output logic machine_stopped_indication
);
  import sfs_pkg::*;

  // ****************************************
  // pin synchronisers and edges
  // ****************************************
  logic [12:0] pin_s;
  logic [12:0] pin_prev_r;
  logic [12:0] pin_rise;
  logic [12:0] pin_fall;
  logic edge_s, panel_s, trim_s, up_s, tick_s, rlift_s, rev_s;
  logic pp_s, altv_s, neut_s, alow_s, comp_s, stop_s;
  sfs_sync #(.W(13)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({edge_sensor_fitted, panel_connected, trim_done, upper_detect, angle_tick,
        reverse_lift_req, reverse_switch, presser_pedal, altv_switch, pedal_neutral,
        auto_lowered, comp_switch, machine_stopped}),
    .q(pin_s)
  );
  assign {edge_s, panel_s, trim_s, up_s, tick_s, rlift_s, rev_s,
          pp_s, altv_s, neut_s, alow_s, comp_s, stop_s} = pin_s;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_prev_r <= 13'h0000;
    end else begin
      pin_prev_r <= pin_s;
    end
  end
  assign pin_rise = pin_s & ~pin_prev_r;
  assign pin_fall = ~pin_s & pin_prev_r;
  logic trim_rise, up_fall, tick_rise, rev_rise, pp_rise, altv_rise, altv_fall;
  logic neut_rise, neut_fall, alow_rise, comp_rise;
  assign trim_rise = pin_rise[10];
  assign up_fall = pin_fall[9];
  assign tick_rise = pin_rise[8];
  assign rev_rise = pin_rise[6];
  assign pp_rise = pin_rise[5];
  assign altv_rise = pin_rise[4];
  assign altv_fall = pin_fall[4];
  assign neut_rise = pin_rise[3];
  assign neut_fall = pin_fall[3];
  assign alow_rise = pin_rise[2];
  assign comp_rise = pin_rise[1];

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: the answer is registered, so pready comes from a flop
  logic pready_r, pslverr_r, acc, commit, mapped;
  sfs_word_t prdata_r, rd_mux;
  logic cnt_en_r, comp_sel_r, nl_en_r;
  sfs_rev_e rev_r;
  sfs_dial_e dial_r;
  sfs_pm_e pm_r;
  logic [3:0] of_r;
  logic [8:0] angle_r, delay_r, lift_r;
  logic [15:0] count_r;
  logic presser_r, wrapper_r, revf_r, altv_out_r, altv_max_r, brake_r;
  logic dial_an_r, dial_dg_r, comp_ud_r, comp_one_r, blank_r, stop_out_r;
  assign acc = psel & penable & ~pready_r;
  assign commit = psel & penable & pready_r & pwrite;
  assign mapped = (paddr == `SFS_A_CTRL) | (paddr == `SFS_A_ANGLE) |
                  (paddr == `SFS_A_DELAY) | (paddr == `SFS_A_LIFT) |
                  (paddr == `SFS_A_COUNT) | (paddr == `SFS_A_STAT);
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SFS_A_CTRL: rd_mux[13:0] = {of_r, pm_r, nl_en_r, comp_sel_r, dial_r, rev_r, cnt_en_r};
      `SFS_A_ANGLE: rd_mux[8:0] = angle_r;
      `SFS_A_DELAY: rd_mux[8:0] = delay_r;
      `SFS_A_LIFT: rd_mux[8:0] = lift_r;
      `SFS_A_COUNT: rd_mux[15:0] = count_r;
      `SFS_A_STAT: rd_mux[6:0] = {stop_s, brake_r, wrapper_r, altv_max_r, altv_out_r,
                                 presser_r, blank_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc & ~mapped;
      if (acc & ~pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ****************************************
  // setting registers
  // ****************************************
  // each field is checked on its own, so one bad field does not void the rest
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_en_r <= 1'b0;
      rev_r <= sfs_rev_normal;
      dial_r <= sfs_dial_none;
      comp_sel_r <= 1'b0;
      nl_en_r <= 1'b0;
      pm_r <= sfs_pm_level;
      of_r <= 4'h0;
    end else if (commit && paddr == `SFS_A_CTRL) begin
      cnt_en_r <= pwdata[`SFS_F_CNT];
      rev_r <= sfs_rev_e'(pwdata[`SFS_F_REV +: 2]);
      comp_sel_r <= pwdata[`SFS_F_COMP];
      nl_en_r <= pwdata[`SFS_F_NL];
      if (pwdata[`SFS_F_DIAL +: 2] <= `SFS_DIAL_MAX) begin
        dial_r <= sfs_dial_e'(pwdata[`SFS_F_DIAL +: 2]);
      end
      if (pwdata[`SFS_F_PM +: 3] <= `SFS_PM_MAX) begin
        pm_r <= sfs_pm_e'(pwdata[`SFS_F_PM +: 3]);
      end
      if (pwdata[`SFS_F_OF +: 4] <= `SFS_OF_MAX) begin
        of_r <= pwdata[`SFS_F_OF +: 4];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      angle_r <= `SFS_ANGLE_RST;
      delay_r <= `SFS_DELAY_RST;
      lift_r <= `SFS_LIFT_RST;
    end else if (commit) begin
      if (paddr == `SFS_A_ANGLE && pwdata[8:0] <= `SFS_ANGLE_MAX && pwdata[31:9] == 23'h0) begin
        angle_r <= pwdata[8:0];
      end
      if (paddr == `SFS_A_DELAY && pwdata[8:0] <= `SFS_DELAY_MAX && pwdata[31:9] == 23'h0) begin
        delay_r <= pwdata[8:0];
      end
      if (paddr == `SFS_A_LIFT && pwdata[8:0] >= `SFS_LIFT_MIN &&
          pwdata[8:0] <= `SFS_LIFT_MAX && pwdata[31:9] == 23'h0) begin
        lift_r <= pwdata[8:0];
      end
    end
  end

  // ****************************************
  // sewing counter
  // ****************************************
  logic cnt_act, cnt_clr;
  assign cnt_act = cnt_en_r & edge_s & ~panel_s;
  assign cnt_clr = commit & (paddr == `SFS_A_COUNT);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_r <= `SFS_COUNT_RST;
      blank_r <= 1'b1;
    end else begin
      blank_r <= ~cnt_act;
      if (trim_rise & cnt_act) begin
        count_r <= cnt_clr ? 16'h0001 : count_r + 16'h0001;
      end else if (cnt_clr) begin
        count_r <= `SFS_COUNT_RST;
      end
    end
  end

  // ****************************************
  // reverse switch, wrapper and presser pedal
  // ****************************************
  logic rev_lvl, pm_lvl, wrap_tog, wrap_sync, ped_hold_r;
  assign rev_lvl = (rev_r == sfs_rev_lvl_sync) | (rev_r == sfs_rev_lvl);
  assign pm_lvl = (pm_r == sfs_pm_wrap_sync) | (pm_r == sfs_pm_wrap_lvl);
  assign wrap_tog = ((rev_r == sfs_rev_alt) & rev_rise) | ((pm_r == sfs_pm_wrap_alt) & pp_rise);
  assign wrap_sync = (rev_r == sfs_rev_lvl_sync) | (pm_r == sfs_pm_wrap_sync);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrapper_r <= 1'b0;
      revf_r <= 1'b0;
    end else begin
      revf_r <= (rev_r == sfs_rev_normal) & rev_s;
      if (wrap_tog) begin
        wrapper_r <= ~wrapper_r;
      end else if (rev_lvl | pm_lvl) begin
        wrapper_r <= (rev_lvl & rev_s) | (pm_lvl & pp_s);
      end else if (rev_r != sfs_rev_alt && pm_r != sfs_pm_wrap_alt) begin
        wrapper_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ped_hold_r <= 1'b0;
      altv_max_r <= 1'b0;
    end else begin
      unique case (pm_r)
        sfs_pm_level: ped_hold_r <= pp_s;
        sfs_pm_toggle: ped_hold_r <= ped_hold_r ^ pp_rise;
        default: ped_hold_r <= 1'b0;
      endcase
      unique case (pm_r)
        sfs_pm_max_lvl: altv_max_r <= pp_s;
        sfs_pm_max_tog: altv_max_r <= altv_max_r ^ pp_rise;
        default: altv_max_r <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // neutral automatic presser lift
  // ****************************************
  logic arm_r, left_r, nl_lift_r, nl_go, nl_done;
  assign nl_go = nl_en_r & arm_r & left_r & neut_rise & ~nl_lift_r;
  sfs_timer #(.MS_CYC(MS_CYC)) u_lift_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(nl_go),
    .ms(lift_r),
    .done(nl_done)
  );
  always_ff @(posedge ref_clk) begin
    if (rst || !nl_en_r) begin
      arm_r <= 1'b0;
      left_r <= 1'b0;
      nl_lift_r <= 1'b0;
    end else if (nl_done) begin
      nl_lift_r <= 1'b0;
      arm_r <= 1'b1;
      left_r <= 1'b0;
    end else if (nl_go) begin
      nl_lift_r <= 1'b1;
      arm_r <= 1'b0;
    end else if (alow_rise) begin
      arm_r <= 1'b1;
      left_r <= 1'b0;
    end else if (arm_r & neut_fall) begin
      left_r <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      presser_r <= 1'b0;
    end else begin
      presser_r <= ped_hold_r | nl_lift_r | (wrap_sync & wrapper_r);
    end
  end

  // ****************************************
  // alternate vertical output delay
  // ****************************************
  logic altv_pend_r, altv_done;
  sfs_timer #(.MS_CYC(MS_CYC)) u_altv_tmr (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(altv_rise),
    .ms(delay_r),
    .done(altv_done)
  );
  always_ff @(posedge ref_clk) begin
    if (rst || altv_fall) begin
      altv_pend_r <= 1'b0;
      altv_out_r <= 1'b0;
    end else if (altv_rise) begin
      altv_pend_r <= 1'b1;
    end else if (altv_done & altv_pend_r & altv_s) begin
      altv_out_r <= 1'b1;
      altv_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // reversing brake start angle
  // ****************************************
  sfs_brk_e brk_r, brk_nxt;
  logic [8:0] deg_r;
  always_comb begin
    brk_nxt = brk_r;
    unique case (brk_r)
      sfs_brk_idle: if (rlift_s) brk_nxt = sfs_brk_wait;
      sfs_brk_wait: if (up_fall) brk_nxt = (angle_r == 9'h000) ? sfs_brk_hold : sfs_brk_turn;
      sfs_brk_turn: if (tick_rise && deg_r + 9'h001 >= angle_r) brk_nxt = sfs_brk_hold;
      sfs_brk_hold: brk_nxt = sfs_brk_hold;
    endcase
    if (!rlift_s) begin
      brk_nxt = sfs_brk_idle;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brk_r <= sfs_brk_idle;
      deg_r <= 9'h000;
      brake_r <= 1'b0;
    end else begin
      brk_r <= brk_nxt;
      brake_r <= (brk_nxt == sfs_brk_hold);
      if (brk_r != sfs_brk_turn) begin
        deg_r <= 9'h000;
      end else if (tick_rise) begin
        deg_r <= deg_r + 9'h001;
      end
    end
  end

  // ****************************************
  // dial, compensation switch, optional output
  // ****************************************
  // only code 10 is built here; other output codes leave the pin low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dial_an_r <= 1'b0;
      dial_dg_r <= 1'b0;
      comp_ud_r <= 1'b0;
      comp_one_r <= 1'b0;
      stop_out_r <= 1'b0;
    end else begin
      dial_an_r <= (dial_r == sfs_dial_analog);
      dial_dg_r <= (dial_r == sfs_dial_digital);
      comp_ud_r <= comp_rise & ~comp_sel_r;
      comp_one_r <= comp_rise & comp_sel_r;
      stop_out_r <= (of_r == `SFS_OF_STOP) & stop_s;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign presser_lift = presser_r;
  assign wrapper_on = wrapper_r;
  assign reverse_feed = revf_r;
  assign altv_out = altv_out_r;
  assign altv_max = altv_max_r;
  assign brake_start = brake_r;
  assign dial_analog_en = dial_an_r;
  assign alternate_vertical_dial_digital = dial_dg_r;
  assign comp_updown = comp_ud_r;
  assign comp_one_stitch = comp_one_r;
  assign count_blank = blank_r;
  assign machine_stopped_indication = stop_out_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_count_step: assert property (
    (trim_rise && cnt_act && !cnt_clr) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step on trim");
  a_count_hold: assert property (
    (!cnt_act && !cnt_clr) |=> $stable(count_r))
    else $error("counter moved while counting inactive");
  a_count_blank: assert property (
    !cnt_act |=> blank_r)
    else $error("count indication not blanked");
  a_angle_keep: assert property (
    (commit && paddr == `SFS_A_ANGLE && pwdata[8:0] > `SFS_ANGLE_MAX) |=> $stable(angle_r))
    else $error("illegal angle accepted");
  a_brake_zero: assert property (
    (brk_r == sfs_brk_wait && up_fall && angle_r == 9'h000 && rlift_s) |=> brake_r)
    else $error("brake not started at upper loss");
  a_altv_delay: assert property (
    (altv_rise && delay_r == 9'h000) ##1 altv_s [*3] |-> altv_out_r)
    else $error("alternate vertical output late");
  a_ped_level: assert property (
    (pm_r == sfs_pm_level) |=> ped_hold_r == $past(pp_s))
    else $error("presser does not follow pedal");
  a_ped_toggle: assert property (
    (pm_r == sfs_pm_toggle && pp_rise) |=> ped_hold_r != $past(ped_hold_r))
    else $error("presser did not toggle");
  a_altv_max: assert property (
    (pm_r == sfs_pm_max_lvl) |=> altv_max_r == $past(pp_s))
    else $error("maximum amount not following pedal");
  a_comp_sel: assert property (
    comp_rise |=> (comp_one_r == $past(comp_sel_r)) && (comp_ud_r != $past(comp_sel_r)))
    else $error("compensation pulse on wrong output");
  a_stop_out: assert property (
    (of_r == `SFS_OF_STOP) |=> stop_out_r == $past(stop_s))
    else $error("stop indication wrong");
  a_nl_second: assert property (
    $rose(nl_lift_r) |-> $past(left_r) && $past(neut_rise))
    else $error("neutral lift without leaving neutral");
endmodule : sfs_top

// *** tb/sfs_operator.sv ***
// operator side model: pedal, switches, panel and machine event pins
`timescale 1ns/100ps
module sfs_operator (
  // clock
  input wire logic ref_clk,
  // pin levels towards the control box
  output logic [12:0] pins
);
  // ****
  // pin handling
  // ****
  initial pins = 13'h0000;
  // levels change just after an edge, no bounce is modelled
  task automatic hold(input int i, input logic v);
    @(posedge ref_clk);
    pins[i] <= v;
  endtask : hold
  // a press long enough for the two-flop synchroniser, then a settled release
  task automatic tap(input int i, input int len);
    hold(i, 1'b1);
    repeat (len) @(posedge ref_clk);
    hold(i, 1'b0);
    repeat (4) @(posedge ref_clk);
  endtask : tap
endmodule : sfs_operator

// *** tb/sewing_function_setting_logic_bench.sv ***
// self-checking bench of the function setting block
`timescale 1ns/100ps
`include "sfs_cfg.svh"
module sewing_function_setting_logic_bench;
  import sfs_pkg::*;
  // ****
  // signals and model state
  // ****
  localparam int MSC = 20;
  localparam int SENS = 0, PANEL = 1, TRIM = 2, UPPER = 3, ANG = 4, RLIFT = 5, REVSW = 6;
  localparam int PEDAL = 7, ALTSW = 8, NEUT = 9, AUTOL = 10, COMPSW = 11, STOP = 12;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  sfs_addr_t paddr = 8'h00;
  sfs_word_t pwdata = 32'h00000000, prdata, rdat;
  logic [12:0] pins;
  logic presser_lift, wrapper_on, reverse_feed, altv_out, altv_max, brake_start;
  logic dial_analog_en, alternate_vertical_dial_digital, comp_updown, comp_one_stitch;
  logic count_blank, machine_stopped_indication;
  int n_fail = 0, compares = 0, m_count = 0, n_ud = 0, n_os = 0;
  int m_reg[int];
  always #25 ref_clk = ~ref_clk;
  // one-cycle pulses are counted rather than sampled at a guessed edge
  always @(posedge ref_clk) begin
    n_ud <= n_ud + (comp_updown === 1'b1);
    n_os <= n_os + (comp_one_stitch === 1'b1);
  end
  sfs_operator i_op (.ref_clk, .pins);
  sfs_top #(.MS_CYC(MSC)) i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .edge_sensor_fitted(pins[SENS]), .panel_connected(pins[PANEL]),
    .trim_done(pins[TRIM]), .upper_detect(pins[UPPER]), .angle_tick(pins[ANG]),
    .reverse_lift_req(pins[RLIFT]), .reverse_switch(pins[REVSW]), .presser_pedal(pins[PEDAL]),
    .altv_switch(pins[ALTSW]), .pedal_neutral(pins[NEUT]), .auto_lowered(pins[AUTOL]),
    .comp_switch(pins[COMPSW]), .machine_stopped(pins[STOP]), .presser_lift, .wrapper_on,
    .reverse_feed, .altv_out, .altv_max, .brake_start, .dial_analog_en,
    .alternate_vertical_dial_digital, .comp_updown, .comp_one_stitch, .count_blank,
    .machine_stopped_indication);
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // no wait count assumed: only the watchdog ends a hung access
  task automatic apb(input logic w, input sfs_addr_t a, input sfs_word_t d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input sfs_addr_t a, input int d);
    apb(1'b1, a, 32'(d));
    if (a == `SFS_A_COUNT) m_count = 0;
    else if (!((a == `SFS_A_ANGLE && d > 359) || (a == `SFS_A_DELAY && d > 500)
        || (a == `SFS_A_LIFT && (d < 1 || d > 500)))) m_reg[a] = d;
  endtask : wr
  task automatic rd(input sfs_addr_t a);
    if (a == `SFS_A_COUNT) m_reg[a] = m_count;
    apb(1'b0, a, 32'h00000000);
    chk(rdat, m_reg.exists(a) ? m_reg[a] : 0);
    chk(rerr, a > `SFS_A_STAT);
  endtask : rd
  function automatic logic obs(input int rv, input int c);
    if (rv) return (c == 0) ? reverse_feed : wrapper_on;
    if (c < 2) return presser_lift;
    return (c < 4) ? altv_max : wrapper_on;
  endfunction : obs
  // press, release, press again: level modes follow, toggle modes hold
  task automatic mode_run(input int rv, input int c);
    int p;
    int t;
    p = rv ? REVSW : PEDAL;
    t = rv ? (c == 3) : (c == 1 || c == 3 || c == 6);
    wr(`SFS_A_CTRL, rv ? c << 1 : c << 7);
    i_op.hold(p, 1'b1);
    tick(5);
    chk(obs(rv, c), 1);
    if ((rv && c == 1) || (!rv && c == 4)) chk(presser_lift, 1);
    i_op.hold(p, 1'b0);
    tick(5);
    chk(obs(rv, c), t);
    i_op.hold(p, 1'b1);
    tick(5);
    i_op.hold(p, 1'b0);
    tick(5);
    chk(obs(rv, c), 0);
  endtask : mode_run
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // ****
  // scenarios
  // ****
  initial begin
    int n;
    void'($urandom(43));
    m_reg[`SFS_A_LIFT] = 100;
    m_reg[`SFS_A_STAT] = 1;
    tick(6);
    rst <= 1'b0;
    tick(2);
    chk(count_blank, 1);
    for (int a = 0; a <= 24; a += 4) rd(a[7:0]);
    m_reg.delete(`SFS_A_STAT);
    i_op.hold(SENS, 1'b1);
    wr(`SFS_A_CTRL, 1);
    n = $urandom_range(4, 1);
    repeat (n) i_op.tap(TRIM, 2);
    m_count += n;
    rd(`SFS_A_COUNT);
    chk(count_blank, 0);
    i_op.hold(PANEL, 1'b1);
    i_op.tap(TRIM, 2);
    rd(`SFS_A_COUNT);
    chk(count_blank, 1);
    i_op.hold(PANEL, 1'b0);
    wr(`SFS_A_COUNT, 0);
    wr(`SFS_A_CTRL, 0);
    i_op.tap(TRIM, 2);
    rd(`SFS_A_COUNT);
    chk(count_blank, 1);
    for (int g = 0; g < 2; g++) begin
      n = g ? $urandom_range(3, 1) : 0;
      wr(`SFS_A_ANGLE, n);
      i_op.hold(UPPER, 1'b1);
      i_op.hold(RLIFT, 1'b1);
      tick(4);
      i_op.hold(UPPER, 1'b0);
      tick(5);
      repeat (n) begin
        chk(brake_start, 0);
        i_op.tap(ANG, 2);
      end
      chk(brake_start, 1);
      i_op.hold(RLIFT, 1'b0);
      tick(5);
    end
    wr(`SFS_A_ANGLE, 360);
    wr(`SFS_A_LIFT, 0);
    rd(`SFS_A_ANGLE);
    rd(`SFS_A_LIFT);
    for (int c = 0; c < 4; c++) mode_run(1, c);
    for (int c = 0; c < 7; c++) mode_run(0, c);
    for (int d = 0; d < 4; d++) begin
      wr(`SFS_A_CTRL, d << 3);
      tick(2);
      chk({alternate_vertical_dial_digital, dial_analog_en}, d < 3 ? d : 2);
    end
    for (int s = 0; s < 2; s++) begin
      wr(`SFS_A_CTRL, s << 5);
      i_op.tap(COMPSW, 3);
      chk(n_ud, 1);
      chk(n_os, s);
    end
    // zero delay: output follows the synchronised press within a few cycles
    i_op.hold(ALTSW, 1'b1);
    tick(8);
    chk(altv_out, 1);
    i_op.hold(ALTSW, 1'b0);
    tick(5);
    chk(altv_out, 0);
    wr(`SFS_A_DELAY, 2);
    wr(`SFS_A_DELAY, 501);
    rd(`SFS_A_DELAY);
    i_op.hold(ALTSW, 1'b1);
    tick(2 * MSC - 5);
    chk(altv_out, 0);
    tick(15);
    chk(altv_out, 1);
    i_op.hold(ALTSW, 1'b0);
    tick(5);
    chk(altv_out, 0);
    wr(`SFS_A_LIFT, 2);
    wr(`SFS_A_CTRL, 1 << 6);
    i_op.hold(NEUT, 1'b1);
    i_op.tap(AUTOL, 2);
    chk(presser_lift, 0);
    i_op.hold(NEUT, 1'b0);
    tick(5);
    i_op.hold(NEUT, 1'b1);
    tick(2 * MSC - 10);
    chk(presser_lift, 1);
    // lift time plus synchroniser, timer start and output register latency
    tick(25);
    chk(presser_lift, 0);
    i_op.hold(STOP, 1'b1);
    wr(`SFS_A_CTRL, 10 << 10);
    tick(2);
    chk(machine_stopped_indication, 1);
    wr(`SFS_A_CTRL, 11 << 10);
    tick(2);
    chk(machine_stopped_indication, 1);
    wr(`SFS_A_CTRL, 9 << 10);
    tick(2);
    chk(machine_stopped_indication, 0);
    final_report;
  end
  // the whole sequence needs under a thousand cycles
  initial begin
    tick(20000);
    n_fail++;
    final_report;
  end
endmodule : sewing_function_setting_logic_bench
